// ===== pkg/dsrp_defs.svh
`ifndef DSRP_DEFS_SVH
`define DSRP_DEFS_SVH
// Notes on behaviour
// RQ1: Serial port is MSB first; cfg bit 6 selects LSB
// RQ2: LSB order then holds for later transfers
// RQ3: Direction bit zero steps address downward
// RQ4: Direction bit one steps address upward
// RQ5: Streams never skip reserved or unmapped addresses
// RQ6: Transfer opens with 16-bit R/W plus address header
// RQ7: Two-wire slave works at 100 and 400 kHz
// RQ8: Two-wire side never drives the clock line
// RQ9: Two-wire register address is a full 16 bits
// RQ10: Answer only when 7-bit slave address matches
// RQ11: Data changes only while clock is low
// RQ12: Start and stop detected as data edges, clock high
// RQ13: Two-wire bytes are eight bits, MSB first, then ack
// RQ14: Receiver acks by holding data low, ninth pulse
// RQ15: Nonacknowledge returns two-wire machine to idle
// RQ16: Top header address bit ignored, taken as zero
// RQ17: Chip select low frames transfer; no byte count
// RQ18: Write bits on rise, read bits driven on fall
// RQ19: Two-wire address follows slave address, high first
// RQ20: Repeated start restarts at slave address matching

// Timing
`define DSRP_CLK_NS 100
`define DSRP_SPI_PERIOD_NS 1600
`define DSRP_I2C_PERIOD_NS 2500
`define DSRP_SPI_QTR ((`DSRP_SPI_PERIOD_NS + 4 * `DSRP_CLK_NS - 1) / (4 * `DSRP_CLK_NS))
`define DSRP_I2C_QTR ((`DSRP_I2C_PERIOD_NS + 4 * `DSRP_CLK_NS - 1) / (4 * `DSRP_CLK_NS))

// Configuration register and header layout
`define DSRP_CFG_ADDR 16'h0000
`define DSRP_CFG_LSB_BIT 6
`define DSRP_CFG_ASC_BIT 5
`define DSRP_CFG_LSB_RESET 1'h0
`define DSRP_CFG_ASC_RESET 1'h0
`define DSRP_ADDR_TOP 16'h3A3B
`define DSRP_HDR_RW_BIT 15
`define DSRP_HDR_ADDR_MSB 13
`define DSRP_HDR_BITS 5'h10
`define DSRP_I2C_BITS 5'h09

// Idle pin levels {sclk, cs_n, sdio, scl, sda}
`define DSRP_PIN_IDLE 5'h0F
`endif

// ===== pkg/dsrp_pkg.sv
package dsrp_pkg;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_RX, I_ACK, I_TX, I_MACK} dsrp_i2c_st_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} dsrp_host_st_t;
endpackage : dsrp_pkg

// ===== pkg/dsrp_if.sv
`timescale 1ns/10ps
interface dsrp_if;
  logic sclk;
  logic cs_n;
  logic sdio_h_o;
  logic sdio_h_oe;
  logic sdio_d_o;
  logic sdio_d_oe;
  logic sdo_o;
  logic sdo_oe;
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sdio;
  logic serial_data_out;
  logic scl;
  logic sda;

  // Wire levels; released lines read high as if pulled up
  assign sdio = sdio_h_oe ? sdio_h_o : (sdio_d_oe ? sdio_d_o : 1'b1);
  assign serial_data_out = sdo_oe ? sdo_o : 1'b1;
  assign scl = ~(scl_h_oe & ~scl_h_o);
  assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

  modport host (output sclk, cs_n, sdio_h_o, sdio_h_oe, scl_h_o, scl_h_oe, sda_h_o, sda_h_oe,
    input sdio, serial_data_out, sda);
  modport dev (input sclk, cs_n, sdio, scl, sda,
    output sdio_d_o, sdio_d_oe, sdo_o, sdo_oe, sda_d_o, sda_d_oe);
endinterface : dsrp_if

// ===== hw/dsrp_dev.sv
`timescale 1ns/10ps
`include "dsrp_defs.svh"

module dsrp_dev
  import dsrp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  dsrp_if.dev link,
  input wire logic use_i2c,
  input wire logic three_wire,
  input wire logic [6:0] slave_addr,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  output logic lsb_first,
  output logic ascend
);

  logic [4:0] meta;
  logic [4:0] sync;
  logic [4:0] prev;
  logic sck_rise, sck_fall, cs_on, din, scl_rise, scl_fall, scl_hi, i2c_start, i2c_stop;
  logic cfg_lsb, cfg_asc, xfer_lsb, hdr_done, rw, dout, sdo_oe, sdio_oe, sda_oe, irw;
  logic next_cfg_lsb, next_cfg_asc, next_xfer_lsb, next_hdr_done, next_rw;
  logic next_dout, next_sdo_oe, next_sdio_oe, next_sda_oe, next_irw;
  logic [3:0] s_cnt, next_s_cnt, icnt, next_icnt;
  logic [1:0] ibyte, next_ibyte;
  logic [15:0] addr, next_addr, sh, next_sh, nsh, next_reg_addr;
  logic [7:0] tx, next_tx, rbyte, next_reg_wdata;
  logic next_reg_wr, next_reg_rd;
  dsrp_i2c_st_t ist, next_ist;

  // Next address in a stream; reserved holes are walked through, not skipped
  function automatic logic [15:0] step(input logic [15:0] a, input logic up);
    step = up ? a + 16'h0001 : a - 16'h0001; // [RQ3] [RQ4] [RQ5]
  endfunction : step

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= `DSRP_PIN_IDLE;
      sync <= `DSRP_PIN_IDLE;
      prev <= `DSRP_PIN_IDLE;
    end
    else
    begin
      meta <= {link.sclk, link.cs_n, link.sdio, link.scl, link.sda};
      sync <= meta;
      prev <= sync;
    end
  end

  // Edge and condition detection on synchronised levels
  assign sck_rise = sync[4] & ~prev[4];
  assign sck_fall = ~sync[4] & prev[4];
  assign cs_on = ~sync[3];
  assign din = sync[2];
  assign scl_rise = sync[1] & ~prev[1]; // Fast-mode phases span many clocks [RQ7]
  assign scl_fall = ~sync[1] & prev[1];
  assign scl_hi = sync[1] & prev[1]; // Both samples high, so a clock edge never looks like a start
  assign i2c_start = scl_hi & prev[0] & ~sync[0]; // [RQ12]
  assign i2c_stop = scl_hi & ~prev[0] & sync[0]; // [RQ12]

  // Next state of both protocol engines and the register port
  always_comb
  begin
    next_cfg_lsb = cfg_lsb;
    next_cfg_asc = cfg_asc;
    next_xfer_lsb = xfer_lsb;
    next_hdr_done = hdr_done;
    next_rw = rw;
    next_dout = dout;
    next_sdo_oe = sdo_oe;
    next_sdio_oe = sdio_oe;
    next_sda_oe = sda_oe;
    next_irw = irw;
    next_s_cnt = s_cnt;
    next_icnt = icnt;
    next_ibyte = ibyte;
    next_addr = addr;
    next_sh = sh;
    next_ist = ist;
    next_reg_addr = reg_addr;
    next_reg_wdata = reg_wdata;
    next_reg_wr = 1'b0;
    next_reg_rd = 1'b0;
    next_tx = reg_rd ? reg_rdata : tx; // Read data arrives with the fetch strobe
    nsh = xfer_lsb ? {din, sh[15:1]} : {sh[14:0], din};
    rbyte = xfer_lsb ? nsh[15:8] : nsh[7:0];
    if (!use_i2c)
    begin
      next_ist = I_IDLE;
      next_sda_oe = 1'b0;
      if (!cs_on)
      begin
        // Frame over: order is picked up only between frames
        next_s_cnt = 4'h0;
        next_hdr_done = 1'b0;
        next_xfer_lsb = cfg_lsb; // [RQ1] [RQ2] [RQ17]
        next_sdo_oe = 1'b0;
        next_sdio_oe = 1'b0;
      end
      else
      begin
        if (sck_rise)
        begin
          next_sh = nsh; // [RQ18]
          next_s_cnt = s_cnt + 4'h1;
          if (!hdr_done && s_cnt == 4'hF)
          begin
            next_s_cnt = 4'h0;
            next_hdr_done = 1'b1;
            next_rw = nsh[`DSRP_HDR_RW_BIT]; // [RQ6]
            next_addr = {2'h0, nsh[`DSRP_HDR_ADDR_MSB:0]}; // [RQ16]
            next_reg_addr = {2'h0, nsh[`DSRP_HDR_ADDR_MSB:0]};
            next_reg_rd = nsh[`DSRP_HDR_RW_BIT];
          end
          else if (hdr_done && s_cnt == 4'h7)
          begin
            next_s_cnt = 4'h0;
            next_addr = step(addr, cfg_asc);
            if (!rw)
            begin
              next_reg_addr = addr;
              next_reg_wdata = rbyte;
              next_reg_wr = 1'b1;
            end
            else
            begin
              next_reg_addr = step(addr, cfg_asc);
              next_reg_rd = 1'b1;
            end
          end
        end
        if (sck_fall && hdr_done && rw)
        begin
          // Read bits change only on the falling clock
          next_dout = xfer_lsb ? tx[0] : tx[7]; // [RQ18]
          next_tx = xfer_lsb ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
          next_sdo_oe = 1'b1;
          next_sdio_oe = three_wire;
        end
      end
    end
    else
    begin
      next_sdo_oe = 1'b0;
      next_sdio_oe = 1'b0;
      next_hdr_done = 1'b0;
      next_s_cnt = 4'h0;
      nsh = {sh[14:0], sync[0]}; // Two-wire bytes are always MSB first [RQ13]
      if (i2c_start)
      begin
        // Fresh or repeated start drops any partial byte
        next_ist = I_ADDR; // [RQ12] [RQ20]
        next_icnt = 4'h0;
        next_sda_oe = 1'b0;
      end
      else if (i2c_stop)
      begin
        next_ist = I_IDLE;
        next_sda_oe = 1'b0;
      end
      else
      begin
        case (ist)
          I_ADDR, I_RX:
          begin
            if (scl_rise)
            begin
              next_sh = nsh; // [RQ11]
              next_icnt = icnt + 4'h1;
            end
            else if (scl_fall && icnt == 4'h8)
            begin
              next_icnt = 4'h0;
              next_ist = I_ACK;
              next_sda_oe = 1'b1; // Ack held low over the ninth pulse [RQ14]
              if (ist == I_ADDR)
              begin
                next_ibyte = 2'h0;
                next_irw = sh[0];
                if (sh[7:1] != slave_addr)
                begin
                  next_ist = I_IDLE; // [RQ10]
                  next_sda_oe = 1'b0;
                end
                else if (sh[0])
                begin
                  next_reg_addr = addr;
                  next_reg_rd = 1'b1;
                end
              end
              else if (ibyte == 2'h0)
              begin
                next_addr = {sh[7:0], addr[7:0]}; // [RQ9] [RQ19]
                next_ibyte = 2'h1;
              end
              else if (ibyte == 2'h1)
              begin
                next_addr = {addr[15:8], sh[7:0]}; // [RQ9] [RQ19]
                next_ibyte = 2'h2;
              end
              else
              begin
                next_reg_addr = addr;
                next_reg_wdata = sh[7:0];
                next_reg_wr = 1'b1;
                next_addr = step(addr, cfg_asc);
              end
            end
          end
          I_ACK:
          begin
            if (scl_fall)
            begin
              // Release ack; a read starts its first bit in the same low phase
              next_ist = irw ? I_TX : I_RX;
              next_sda_oe = irw & ~tx[7]; // [RQ11] [RQ13]
              next_tx = {tx[6:0], 1'b0};
              next_icnt = irw ? 4'h1 : 4'h0;
            end
          end
          I_TX:
          begin
            if (scl_fall)
            begin
              next_icnt = icnt + 4'h1;
              next_sda_oe = ~tx[7]; // [RQ11]
              next_tx = {tx[6:0], 1'b0};
              if (icnt == 4'h8)
              begin
                next_ist = I_MACK;
                next_sda_oe = 1'b0;
              end
            end
          end
          I_MACK:
          begin
            if (scl_rise)
            begin
              if (sync[0])
                next_ist = I_IDLE; // [RQ15]
              else
              begin
                next_ist = I_ACK;
                next_addr = step(addr, cfg_asc);
                next_reg_addr = step(addr, cfg_asc);
                next_reg_rd = 1'b1;
              end
            end
          end
          default:
          begin
            next_sda_oe = 1'b0;
          end
        endcase
      end
    end
    // Configuration bits live here as well as in the user's copy
    if (next_reg_wr && next_reg_addr == `DSRP_CFG_ADDR)
    begin
      next_cfg_lsb = next_reg_wdata[`DSRP_CFG_LSB_BIT]; // [RQ1] [RQ2]
      next_cfg_asc = next_reg_wdata[`DSRP_CFG_ASC_BIT]; // [RQ3] [RQ4]
    end
  end

  // State registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_lsb <= `DSRP_CFG_LSB_RESET;
      cfg_asc <= `DSRP_CFG_ASC_RESET;
      xfer_lsb <= `DSRP_CFG_LSB_RESET;
      hdr_done <= 1'b0;
      rw <= 1'b0;
      dout <= 1'b1;
      sdo_oe <= 1'b0;
      sdio_oe <= 1'b0;
      sda_oe <= 1'b0;
      irw <= 1'b0;
      s_cnt <= 4'h0;
      icnt <= 4'h0;
      ibyte <= 2'h0;
      addr <= 16'h0000;
      sh <= 16'h0000;
      tx <= 8'h00;
      ist <= I_IDLE;
      reg_addr <= 16'h0000;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
    else
    begin
      cfg_lsb <= next_cfg_lsb;
      cfg_asc <= next_cfg_asc;
      xfer_lsb <= next_xfer_lsb;
      hdr_done <= next_hdr_done;
      rw <= next_rw;
      dout <= next_dout;
      sdo_oe <= next_sdo_oe;
      sdio_oe <= next_sdio_oe;
      sda_oe <= next_sda_oe;
      irw <= next_irw;
      s_cnt <= next_s_cnt;
      icnt <= next_icnt;
      ibyte <= next_ibyte;
      addr <= next_addr;
      sh <= next_sh;
      tx <= next_tx;
      ist <= next_ist;
      reg_addr <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      reg_wr <= next_reg_wr;
      reg_rd <= next_reg_rd;
    end
  end

  // Pins; two-wire data line is only ever pulled low, clock line is input only
  assign link.sdo_o = dout;
  assign link.sdo_oe = sdo_oe;
  assign link.sdio_d_o = dout;
  assign link.sdio_d_oe = sdio_oe;
  assign link.sda_d_o = 1'b0; // [RQ8]
  assign link.sda_d_oe = sda_oe;
  assign lsb_first = cfg_lsb;
  assign ascend = cfg_asc;

endmodule : dsrp_dev

// ===== hw/dsrp_host.sv
`timescale 1ns/10ps
`include "dsrp_defs.svh"

module dsrp_host
  import dsrp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  dsrp_if.host link,
  input wire logic three_wire,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_i2c,
  input wire logic cmd_read,
  input wire logic cmd_lsb,
  input wire logic [6:0] cmd_slave,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] wdata,
  output logic wdata_take,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic nack_err
);

  localparam logic [3:0] SPI_Q = 4'(`DSRP_SPI_QTR - 1);
  localparam logic [3:0] I2C_Q = 4'(`DSRP_I2C_QTR - 1);

  logic [2:0] meta;
  logic [2:0] sync;
  dsrp_host_st_t st, next_st;
  logic [1:0] qtr, next_qtr;
  logic [3:0] qcnt, next_qcnt;
  logic [4:0] bitn, next_bitn;
  logic [2:0] ustep, next_ustep;
  logic [7:0] len, next_len, rsh, next_rsh, nrsh, next_rdata;
  logic [15:0] osh, next_osh, addr, next_addr;
  logic [6:0] slv, next_slv;
  logic is_i2c, rd, lsb, sclk, cs_n, sdio_o, sdio_oe, scl_low, sda_low;
  logic next_is_i2c, next_rd, next_lsb, next_sclk, next_cs_n, next_sdio_o, next_sdio_oe;
  logic next_scl_low, next_sda_low, next_take, next_rvalid, next_nack;
  logic b, qend, host_tx, last;

  // Return pins {sdio, sdo, sda} through two flops
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= 3'h7;
      sync <= 3'h7;
    end
    else
    begin
      meta <= {link.sdio, link.serial_data_out, link.sda};
      sync <= meta;
    end
  end

  // Each bit is four quarters: clock low, data set, clock high, sample
  always_comb
  begin
    next_st = st;
    next_qtr = qtr;
    next_qcnt = qcnt;
    next_bitn = bitn;
    next_ustep = ustep;
    next_len = len;
    next_rsh = rsh;
    next_rdata = rdata;
    next_osh = osh;
    next_addr = addr;
    next_slv = slv;
    next_is_i2c = is_i2c;
    next_rd = rd;
    next_lsb = lsb;
    next_sclk = sclk;
    next_cs_n = cs_n;
    next_sdio_o = sdio_o;
    next_sdio_oe = sdio_oe;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    next_take = 1'b0;
    next_rvalid = 1'b0;
    next_nack = 1'b0;
    b = is_i2c ? sync[0] : (three_wire ? sync[2] : sync[1]);
    nrsh = lsb ? {b, rsh[7:1]} : {rsh[6:0], b};
    qend = qcnt == (is_i2c ? I2C_Q : SPI_Q);
    host_tx = ~(rd & (ustep == 3'h4));
    last = (ustep == 3'h4) && (len == 8'h01);
    if (st == H_IDLE)
    begin
      if (cmd_valid)
      begin
        next_is_i2c = cmd_i2c;
        next_rd = cmd_read;
        next_lsb = cmd_i2c ? 1'b0 : cmd_lsb;
        next_slv = cmd_slave;
        next_addr = cmd_addr;
        next_len = cmd_len;
        next_qtr = 2'h0;
        next_qcnt = 4'h0;
        next_ustep = 3'h0;
        if (cmd_i2c)
        begin
          next_st = H_START;
          next_scl_low = 1'b1;
          next_osh = {cmd_slave, 1'b0, 8'h00};
        end
        else
        begin
          next_st = H_BITS;
          next_cs_n = 1'b0; // [RQ17]
          next_osh = {cmd_read, cmd_addr[`DSRP_HDR_RW_BIT - 1:0]}; // Top address bit as given [RQ6]
          next_bitn = `DSRP_HDR_BITS;
        end
      end
    end
    else
    begin
      next_qcnt = qend ? 4'h0 : qcnt + 4'h1;
      if (qend)
      begin
        next_qtr = qtr + 2'h1;
        case (qtr)
          2'h0:
          begin
            // Data moves a quarter after the clock fell
            if (st == H_START)
              next_sda_low = 1'b0;
            else if (st == H_STOP)
              next_sda_low = 1'b1;
            else if (!is_i2c)
            begin
              next_sdio_o = lsb ? osh[0] : osh[15];
              next_sdio_oe = host_tx;
            end
            else if (bitn == 5'h01)
              next_sda_low = host_tx ? 1'b0 : (len != 8'h01); // [RQ14] [RQ15]
            else
              next_sda_low = host_tx & ~osh[15]; // [RQ11] [RQ13]
          end
          2'h1:
          begin
            next_sclk = ~is_i2c;
            next_scl_low = 1'b0;
          end
          2'h2:
          begin
            // Data edges with the clock high make start and stop
            if (st == H_START)
              next_sda_low = 1'b1; // [RQ12]
            else if (st == H_STOP)
              next_sda_low = 1'b0; // [RQ12]
          end
          default:
          begin
            if (st == H_START)
            begin
              next_st = H_BITS;
              next_bitn = `DSRP_I2C_BITS;
              next_scl_low = 1'b1;
            end
            else if (st == H_STOP)
              next_st = H_IDLE;
            else
            begin
              // Sample at the end of the high phase [RQ18]
              next_osh = lsb ? {1'b0, osh[15:1]} : {osh[14:0], 1'b0};
              next_bitn = bitn - 5'h01;
              next_sclk = 1'b0;
              next_scl_low = is_i2c;
              if (!is_i2c || bitn != 5'h01)
                next_rsh = nrsh;
              if (bitn == 5'h01 && !is_i2c)
              begin
                next_bitn = 5'h08;
                next_ustep = 3'h4;
                next_sdio_oe = ~rd; // Free the data pin before the device answers [RQ18]
                if (ustep == 3'h4)
                begin
                  next_len = len - 8'h01;
                  next_rdata = nrsh;
                  next_rvalid = rd;
                end
                if (last)
                begin
                  next_st = H_IDLE;
                  next_cs_n = 1'b1; // [RQ17]
                  next_sdio_oe = 1'b0;
                end
                else if (!rd)
                begin
                  next_osh = lsb ? {8'h00, wdata} : {wdata, 8'h00}; // [RQ5]
                  next_take = 1'b1;
                end
              end
              else if (bitn == 5'h01 && host_tx && b)
              begin
                next_nack = 1'b1;
                next_st = H_STOP;
              end
              else if (bitn == 5'h01)
              begin
                next_bitn = `DSRP_I2C_BITS;
                case (ustep)
                  3'h0:
                  begin
                    next_ustep = 3'h1;
                    next_osh = {addr[15:8], 8'h00}; // [RQ19]
                  end
                  3'h1:
                  begin
                    next_ustep = 3'h2;
                    next_osh = {addr[7:0], 8'h00}; // [RQ19]
                  end
                  3'h2:
                  begin
                    next_ustep = rd ? 3'h3 : 3'h4;
                    next_st = rd ? H_START : H_BITS;
                    next_osh = rd ? {slv, 1'b1, 8'h00} : {wdata, 8'h00};
                    next_take = ~rd;
                  end
                  3'h3:
                    next_ustep = 3'h4;
                  default:
                  begin
                    next_len = len - 8'h01;
                    next_rdata = rsh;
                    next_rvalid = rd;
                    if (last)
                      next_st = H_STOP;
                    else if (!rd)
                    begin
                      next_osh = {wdata, 8'h00};
                      next_take = 1'b1;
                    end
                  end
                endcase
              end
            end
          end
        endcase
      end
    end
  end

  // State registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= H_IDLE;
      qtr <= 2'h0;
      qcnt <= 4'h0;
      bitn <= 5'h00;
      ustep <= 3'h0;
      len <= 8'h00;
      rsh <= 8'h00;
      rdata <= 8'h00;
      osh <= 16'h0000;
      addr <= 16'h0000;
      slv <= 7'h00;
      is_i2c <= 1'b0;
      rd <= 1'b0;
      lsb <= 1'b0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      sdio_o <= 1'b0;
      sdio_oe <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      wdata_take <= 1'b0;
      rdata_valid <= 1'b0;
      nack_err <= 1'b0;
    end
    else
    begin
      st <= next_st;
      qtr <= next_qtr;
      qcnt <= next_qcnt;
      bitn <= next_bitn;
      ustep <= next_ustep;
      len <= next_len;
      rsh <= next_rsh;
      rdata <= next_rdata;
      osh <= next_osh;
      addr <= next_addr;
      slv <= next_slv;
      is_i2c <= next_is_i2c;
      rd <= next_rd;
      lsb <= next_lsb;
      sclk <= next_sclk;
      cs_n <= next_cs_n;
      sdio_o <= next_sdio_o;
      sdio_oe <= next_sdio_oe;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
      wdata_take <= next_take;
      rdata_valid <= next_rvalid;
      nack_err <= next_nack;
    end
  end

  // Open-drain lines are only ever pulled low
  assign cmd_ready = st == H_IDLE;
  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.sdio_h_o = sdio_o;
  assign link.sdio_h_oe = sdio_oe;
  assign link.scl_h_o = 1'b0;
  assign link.scl_h_oe = scl_low;
  assign link.sda_h_o = 1'b0;
  assign link.sda_h_oe = sda_low;

endmodule : dsrp_host

// ===== test/dsrp_asserts.sv
`timescale 1ns/10ps
module dsrp_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_data_out,
  input wire logic sdo_oe,
  input wire logic sdio_h_oe,
  input wire logic sdio_d_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Read drive lives inside a frame only
  property p_oe_in; (sdo_oe || sdio_d_oe) |-> !$past(cs_n, 5); endproperty
  property p_oe_off; $rose(cs_n) |-> ##[1:5] !(sdo_oe || sdio_d_oe); endproperty
  property p_one; !(sdio_h_oe && sdio_d_oe); endproperty
  property p_rd; $changed(serial_data_out) && !cs_n && $past(sdo_oe) |-> !sclk && !$past(sclk, 2); endproperty
  // Two-wire drive moves in the low phase only
  property p_chg; $changed(sda_d_oe) |-> !scl && !$past(scl); endproperty
  property p_hold; sda_d_oe && scl |=> sda_d_oe || !scl; endproperty
  property p_len; $rose(sda_d_oe) |-> sda_d_oe[*8]; endproperty
  property p_stop; scl && $past(scl) && $rose(sda) |=> (!sda_d_oe)[*4]; endproperty
  a_oe_in: assert property (p_oe_in) else $error("drive out of frame");
  a_oe_off: assert property (p_oe_off) else $error("drive kept");
  a_one: assert property (p_one) else $error("sdio clash");
  a_rd: assert property (p_rd) else $error("read bit moved");
  a_chg: assert property (p_chg) else $error("sda moved high");
  a_hold: assert property (p_hold) else $error("sda dropped");
  a_len: assert property (p_len) else $error("ack short");
  a_stop: assert property (p_stop) else $error("drive after stop");
  c_frame: cover property ($fell(cs_n));
  c_ack: cover property ($rose(sda_d_oe));
  c_start: cover property (scl && $fell(sda));
endmodule : dsrp_asserts

// ===== test/test_dual_serial_register_port.sv
`timescale 1ns/10ps
module test_dual_serial_register_port;
  logic clk = 0, rst = 1, use_i2c = 0, three_w = 0, cmd_valid = 0, cmd_i2c = 0;
  logic cmd_read = 0, cmd_lsb = 0, cmd_ready, wdata_take, rdata_valid, nack_err;
  logic reg_wr, reg_rd, lsb_first, ascend;
  logic [6:0] cmd_slave = 7'h2A;
  logic [15:0] cmd_addr = 16'h0000, reg_addr, hdr, wa [$];
  logic [7:0] cmd_len = 8'h01, wdata = 8'h00, rdata, reg_wdata, mem [256], rq [$];
  int err_total = 0, compares = 0, nscl = 0, nbit = 0, nack = 0;
  dsrp_if u_dsrp_if ();
  dsrp_dev u_dsrp_dev (.clk, .rst, .link(u_dsrp_if), .use_i2c, .three_wire(three_w),
    .slave_addr(7'h2A), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata(mem[reg_addr[7:0]]), .lsb_first, .ascend);
  dsrp_host u_dsrp_host (.clk, .rst, .link(u_dsrp_if), .three_wire(three_w), .cmd_valid,
    .cmd_ready, .cmd_i2c, .cmd_read, .cmd_lsb, .cmd_slave, .cmd_addr, .cmd_len, .wdata,
    .wdata_take, .rdata, .rdata_valid, .nack_err);
  dsrp_asserts u_dsrp_asserts (.clk, .rst, .sclk(u_dsrp_if.sclk), .cs_n(u_dsrp_if.cs_n),
    .serial_data_out(u_dsrp_if.serial_data_out), .sdo_oe(u_dsrp_if.sdo_oe), .sdio_h_oe(u_dsrp_if.sdio_h_oe),
    .sdio_d_oe(u_dsrp_if.sdio_d_oe), .scl(u_dsrp_if.scl), .sda(u_dsrp_if.sda),
    .sda_d_oe(u_dsrp_if.sda_d_oe));
  // 10 MHz clock
  always #50 clk = ~clk;
  // Register file behind the device; no stall, as the port cannot wait
  always @(posedge clk)
  begin
    if (reg_wr)
      mem[reg_addr[7:0]] <= reg_wdata;
    if (reg_wr)
      wa.push_back(reg_addr);
    if (rdata_valid)
      rq.push_back(rdata);
    if (wdata_take)
      wdata <= wdata + 8'h01;
    if (nack_err)
      nack++;
  end
  // Header bits as they travel on the wire
  always @(posedge u_dsrp_if.sclk)
    if (!u_dsrp_if.cs_n && nbit < 16)
    begin
      hdr = {hdr[14:0], u_dsrp_if.sdio};
      nbit++;
    end
  always @(posedge u_dsrp_if.scl)
    nscl++;
  task automatic chk(input logic [15:0] g, e);
    compares++;
    if (g !== e)
      err_total++;
    if (g !== e)
      $display("[ERR] %0t got %h exp %h", $time, g, e);
  endtask : chk
  task automatic stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // Protocol is switched while reset is held, so both engines start clean
  task automatic reset_to(input logic i);
    rst <= 1'b1;
    use_i2c <= i;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : reset_to
  // One host command, mode is {two-wire, read, lsb first}
  task automatic xfer(input logic [2:0] m, input logic [15:0] a, input logic [7:0] n, d);
    int k;
    wa.delete();
    rq.delete();
    nscl = 0;
    nbit = 0;
    {cmd_i2c, cmd_read, cmd_lsb} <= m;
    cmd_addr <= a;
    cmd_len <= n;
    wdata <= d;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (k = 0; k < 20000 && !(cmd_ready && k > 2); k++)
      @(posedge clk);
    if (k == 20000)
      err_total++;
    if (k == 20000)
      stop_test();
    repeat (4) @(posedge clk);
  endtask : xfer
  task automatic t_spi;
    xfer(3'b000, 16'h4012, 8'h03, 8'h51);
    chk(hdr, 16'h4012);
    chk(wa[0], 16'h0012);
    chk(wa[2], 16'h0010);
    for (int w = 0; w < 2; w++)
    begin
      three_w <= w[0];
      xfer(3'b010, 16'h0011, 8'h02, 8'h00);
      chk(hdr, 16'h8011);
      chk(rq[0], 8'h52);
      chk(rq[1], 8'h53);
    end
    $display("end spi");
  endtask : t_spi
  task automatic t_lsb;
    xfer(3'b000, 16'h0000, 8'h01, 8'h60);
    chk(lsb_first, 1'b1);
    chk(ascend, 1'b1);
    xfer(3'b001, 16'h0020, 8'h02, 8'h71);
    chk(hdr, 16'h0400);
    chk(wa[1], 16'h0021);
    chk(mem[8'h21], 8'h72);
    $display("end lsb");
  endtask : t_lsb
  task automatic t_i2c;
    reset_to(1'b1);
    chk(ascend, 1'b0);
    xfer(3'b100, 16'h0031, 8'h02, 8'h81);
    chk(16'(nscl), 16'h002F);
    chk(wa[0], 16'h0031);
    chk(wa[1], 16'h0030);
    xfer(3'b110, 16'h0031, 8'h02, 8'h00);
    chk(rq[1], 8'h82);
    cmd_slave <= 7'h2B;
    xfer(3'b100, 16'h0040, 8'h01, 8'h99);
    chk(16'(nack), 16'h0001);
    chk(mem[8'h40], 8'hE0);
    cmd_slave <= 7'h2A;
    xfer(3'b110, 16'h0030, 8'h01, 8'h00);
    chk(rq[0], 8'h82);
    $display("end i2c");
  endtask : t_i2c
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'hA0 ^ 8'(i);
    reset_to(1'b0);
    t_spi();
    t_lsb();
    t_i2c();
    stop_test();
  end
endmodule : test_dual_serial_register_port
